// ---- src/ebc_top.sv ----
// Expansion bus transfer controller with Wishbone registers and DMA port
`timescale 1ns/1ps
`include "ebc_params.svh"

module ebc_top
   import ebc_pkg::*;
#(
   parameter int unsigned TMO_W = 4
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output ebc_dma_t         dma_o,
   input  wire logic        dma_ack_i,
   input  wire logic [31:0] dma_rdata_i,
   output ebc_pins_t        ebus_o,
   input  wire logic [15:0] ad_i,
   input  wire logic        target_ack_ready_i,
   input  wire logic        ext_halt_i
);
   if (TMO_W != 4) begin : g_chk
      $error("TMO_W must match the 4-bit timeout field");
   end

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic        ack_m_ff, ack_s_ff, halt_m_ff, halt_s_ff;
   logic [15:0] ad_m_ff, ad_s_ff;

   // two flops on every pin input
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_m_ff  <= 1'b1;
         ack_s_ff  <= 1'b1;
         halt_m_ff <= 1'b1;
         halt_s_ff <= 1'b1;
         ad_m_ff   <= 16'h0000;
         ad_s_ff   <= 16'h0000;
      end else begin
         ack_m_ff  <= target_ack_ready_i;
         ack_s_ff  <= ack_m_ff;
         halt_m_ff <= ext_halt_i;
         halt_s_ff <= halt_m_ff;
         ad_m_ff   <= ad_i;
         ad_s_ff   <= ad_m_ff;
      end
   end

   // ------------------------------------------------------------
   // Registers and decode
   // ------------------------------------------------------------
   ebc_state_t  state_ff, nxt_state;
   logic [31:0] cfg_ff, cmd_ff, ad_ff, wbuf_ff, wb_dat_ff;
   logic        wb_ack_ff, start_ff, ti_ff, fe_ff;
   logic [15:0] taddr_ff;
   logic [3:0]  tmr_ff, init_lo_ff;
   logic [1:0]  bptr_ff;
   logic        block_ff, write_ff, addr_sent_ff;
   logic [31:0] wmask;

   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign wmask[8*i +: 8] = {8{wb_sel_i[i]}};
   end

   wire wb_req  = wb_cyc_i & wb_stb_i;
   wire wb_wr   = wb_req & wb_we_i & wb_ack_ff;
   wire hit_cfg = wb_adr_i == `EBC_OFF_CFG;
   wire hit_cmd = wb_adr_i == `EBC_OFF_CMD;
   wire hit_ad  = wb_adr_i == `EBC_OFF_AD;
   wire hit_st  = wb_adr_i == `EBC_OFF_STAT;
   wire busy    = (state_ff != ST_IDLE) | start_ff;

   wire [31:0] new_cfg = ((cfg_ff & ~wmask) | (wb_dat_i & wmask)) & `EBC_CFG_MASK;
   wire [31:0] new_cmd = (cmd_ff & ~wmask) | (wb_dat_i & wmask);
   wire [31:0] new_ad  = (ad_ff & ~wmask) | (wb_dat_i & wmask);
   wire [14:0] new_cnt = new_cmd[`EBC_CMD_CNT_HI:`EBC_CMD_CNT_LO];
   wire        new_imm = (new_cnt != 15'h0000) & (new_cnt <= `EBC_IMM_MAX);
   wire [2:0]  new_end = {1'b0, new_cmd[1:0]} + new_cnt[2:0];
   wire        new_bad = new_imm & (new_end > 3'h4);
   // Commands written while a transfer runs are dropped
   wire        wr_cmd  = wb_wr & hit_cmd & ~busy;
   wire        cmd_go  = wr_cmd & (new_cnt != 15'h0000) & ~new_bad;
   wire        fe_set  = wr_cmd & new_bad;

   wire        halt_en = cfg_ff[`EBC_CFG_HALT_EN];
   wire        resume  = cfg_ff[`EBC_CFG_RESUME];
   wire        fast    = cfg_ff[`EBC_CFG_FAST];
   wire [3:0]  tmo     = cfg_ff[`EBC_CFG_TMO_HI:`EBC_CFG_TMO_LO];
   wire        slave16 = cfg_ff[`EBC_CFG_SLAVE16];
   wire        incr    = cfg_ff[`EBC_CFG_INC];
   wire        latch   = cfg_ff[`EBC_CFG_LATCH];
   wire        timer_enable_n_n  = cfg_ff[`EBC_CFG_TIMER_ENABLE_N_N];
   wire [14:0] cnt     = cmd_ff[`EBC_CMD_CNT_HI:`EBC_CMD_CNT_LO];
   wire        cmd_blk = cnt > `EBC_IMM_MAX;

   wire [31:0] stat_rd = {29'h0000_0000, fe_ff, ti_ff, state_ff != ST_IDLE};
   wire [31:0] rd_mux  = hit_cfg ? cfg_ff :
                         hit_cmd ? cmd_ff :
                         hit_ad  ? ad_ff  :
                         hit_st  ? stat_rd : 32'h0000_0000;

   // ------------------------------------------------------------
   // Cycle timing terms
   // ------------------------------------------------------------
   wire        two     = slave16 & ~bptr_ff[0] & (cnt > 15'h0001);
   wire [14:0] bp      = two ? 15'h0002 : 15'h0001;
   wire [1:0]  bp2     = two ? 2'h2 : 2'h1;
   wire        tmr_exp = tmr_ff == tmo;
   // latch style holds at expiry until ready is high
   wire        end_lat = tmr_exp & ((tmo == 4'h0) | ack_s_ff);
   // data-strobe style ends at expiry or on acknowledge
   wire        end_ds  = (tmr_exp & (~timer_enable_n_n | (tmo == 4'h0))) | ~ack_s_ff;
   wire        st_done = (state_ff == ST_DATA) & (latch ? end_lat : end_ds);
   // idle length; the fast bit is ignored with increment
   wire [3:0]  gap_len = incr ? (write_ff ? `EBC_GAP_INC_WR : `EBC_GAP_INC_RD) :
                         (fast ? `EBC_GAP_FAST : `EBC_GAP_NORM);
   // no new cycle while the target still holds its line low
   wire        gap_ok  = (tmr_ff >= gap_len - 4'h1) & ((tmo == 4'h0) | ack_s_ff);
   wire        adr_ok  = tmr_ff == `EBC_ADDR_CLKS - 4'h1;
   wire        halt_rq = block_ff & halt_en & ~halt_s_ff;
   wire        word_dn = (bptr_ff == 2'h0) | (cnt == 15'h0000);
   wire [2:0]  init_sm = {1'b0, init_lo_ff[3:2]} + {1'b0, init_lo_ff[1:0]};
   wire        aligned = (init_lo_ff[1:0] == 2'h0) | (init_sm == 3'h4);
   wire [7:0]  wbyte   = wbuf_ff[{bptr_ff, 3'h0} +: 8];
   wire [15:0] whalf   = wbuf_ff[{bptr_ff[1], 4'h0} +: 16];
   wire [7:0]  rbyte   = bptr_ff[0] ? ad_s_ff[15:8] : ad_s_ff[7:0];

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   ebc_state_t nxt_cycle;

   // halt checks fall on cycle boundaries only
   always_comb begin
      if (halt_rq & resume) begin
         nxt_cycle = ST_HALT;
      end else if (halt_rq & (bptr_ff == 2'h0)) begin
         nxt_cycle = ST_FIN;
      end else if (block_ff & write_ff & (bptr_ff == 2'h0)) begin
         nxt_cycle = ST_FETCH;
      end else if (incr | ~addr_sent_ff) begin
         nxt_cycle = ST_ADDR;
      end else begin
         nxt_cycle = ST_DATA;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start_ff) begin
               nxt_state = (cmd_blk & ~cmd_ff[`EBC_CMD_WRN]) ? ST_FETCH : ST_ADDR;
            end
         end
         ST_FETCH: begin
            if (dma_ack_i) begin
               nxt_state = (incr | ~addr_sent_ff) ? ST_ADDR : ST_DATA;
            end
         end
         ST_ADDR: begin
            if (adr_ok) begin
               nxt_state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (st_done) begin
               nxt_state = ST_GAP;
            end
         end
         ST_GAP: begin
            if (gap_ok) begin
               if (word_dn & block_ff & ~write_ff) begin
                  nxt_state = ST_STORE;
               end else if (cnt == 15'h0000) begin
                  nxt_state = ST_FIN;
               end else begin
                  nxt_state = nxt_cycle;
               end
            end
         end
         ST_STORE: begin
            if (dma_ack_i) begin
               nxt_state = (cnt == 15'h0000) ? ST_FIN : nxt_cycle;
            end
         end
         ST_HALT: begin
            if (~halt_rq) begin
               nxt_state = nxt_cycle;
            end
         end
         ST_FIN: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // timer restarts on every state change
   always_ff @(posedge clk_i) begin
      if (rst_i | (state_ff != nxt_state)) begin
         tmr_ff <= 4'h0;
      end else if (~((state_ff == ST_DATA) & tmr_exp) & (tmr_ff != 4'hF)) begin
         tmr_ff <= tmr_ff + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Software registers and flags
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_ff <= 1'b0;
         wb_dat_ff <= 32'h0000_0000;
         cfg_ff    <= `EBC_CFG_RST;
         start_ff  <= 1'b0;
         ti_ff     <= 1'b0;
         fe_ff     <= 1'b0;
      end else begin
         wb_ack_ff <= wb_req & ~wb_ack_ff;
         wb_dat_ff <= rd_mux;
         start_ff  <= cmd_go;
         if (wb_wr & hit_cfg) begin
            cfg_ff <= new_cfg;
         end
         // set wins over a same-cycle write-one clear
         ti_ff <= ((state_ff == ST_DATA) & tmr_exp & (latch | ~timer_enable_n_n)) |
                  (ti_ff & ~(wb_wr & hit_st & wb_sel_i[0] & wb_dat_i[`EBC_ST_TI]));
         fe_ff <= fe_set |
                  (fe_ff & ~(wb_wr & hit_st & wb_sel_i[0] & wb_dat_i[`EBC_ST_FE]));
      end
   end

   // ------------------------------------------------------------
   // Transfer datapath
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff     <= ST_IDLE;
         cmd_ff       <= `EBC_CMD_RST;
         ad_ff        <= `EBC_AD_RST;
         wbuf_ff      <= 32'h0000_0000;
         taddr_ff     <= 16'h0000;
         bptr_ff      <= 2'h0;
         init_lo_ff   <= 4'h0;
         block_ff     <= 1'b0;
         write_ff     <= 1'b0;
         addr_sent_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (wr_cmd) begin
            cmd_ff <= new_cmd;
         end
         if (wb_wr & hit_ad & ~busy) begin
            ad_ff <= new_ad;
         end
         // load from the command and address/data words
         if ((state_ff == ST_IDLE) & start_ff) begin
            block_ff     <= cmd_blk;
            write_ff     <= ~cmd_ff[`EBC_CMD_WRN];
            taddr_ff     <= cmd_ff[15:0];
            bptr_ff      <= cmd_ff[1:0];
            init_lo_ff   <= {cmd_ff[`EBC_CMD_CNT_LO+1:`EBC_CMD_CNT_LO], cmd_ff[1:0]};
            wbuf_ff      <= ad_ff;
            addr_sent_ff <= 1'b0;
         end
         if (((state_ff == ST_FETCH) | (state_ff == ST_STORE)) & dma_ack_i) begin
            ad_ff <= ad_ff + `EBC_WORD_STEP;
            if (state_ff == ST_FETCH) begin
               wbuf_ff <= dma_rdata_i;
            end
         end
         if ((state_ff == ST_ADDR) & adr_ok) begin
            addr_sent_ff <= 1'b1;
         end
         if (state_ff == ST_HALT) begin
            addr_sent_ff <= 1'b0;
         end
         // live remaining count after every data phase
         if (st_done) begin
            cmd_ff[`EBC_CMD_CNT_HI:`EBC_CMD_CNT_LO] <= cnt - bp;
            bptr_ff <= bptr_ff + bp2;
            if (incr) begin
               taddr_ff <= taddr_ff + {14'h0000, bp2};
            end
            if (~write_ff & two) begin
               wbuf_ff[{bptr_ff[1], 4'h0} +: 16] <= ad_s_ff;
            end else if (~write_ff) begin
               wbuf_ff[{bptr_ff, 3'h0} +: 8] <= rbyte;
            end
         end
         if ((state_ff == ST_FIN) & ~write_ff) begin
            if (~block_ff) begin
               ad_ff <= wbuf_ff;
            // unaligned read block points one word further
            end else if (~aligned) begin
               ad_ff <= ad_ff + `EBC_WORD_STEP;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Pin outputs one cycle behind the state; DMA request registered from the next state
   // ------------------------------------------------------------
   ebc_pins_t nxt_pins;
   ebc_dma_t  nxt_dma;
   wire       s_adr = state_ff == ST_ADDR;
   wire       s_dat = state_ff == ST_DATA;
   wire       hi_ln = two | bptr_ff[0];
   wire       lo_ln = two | ~bptr_ff[0];
   wire       in_tr = ~((state_ff == ST_IDLE) | (state_ff == ST_FIN) |
                        (state_ff == ST_HALT));

   always_comb begin
      nxt_pins.addr_latch_n = ~(s_adr | s_dat | (~incr & addr_sent_ff & in_tr));
      nxt_pins.byte_high_n  = ~(latch & hi_ln & (s_adr | s_dat));
      // lines float unless address or write data is driven
      nxt_pins.ad_oe_n      = ~(s_adr | (write_ff & s_dat));
      nxt_pins.ad           = s_adr ? taddr_ff : (two ? whalf : {wbyte, wbyte});
      nxt_pins.read_write_n = ~(write_ff & in_tr & ~latch);
      if (latch) begin
         nxt_pins.upper_strobe_write_n = ~(s_dat & write_ff);
         nxt_pins.lower_strobe_read_n  = ~(s_dat & ~write_ff);
      end else begin
         nxt_pins.upper_strobe_write_n = ~(s_dat & hi_ln);
         nxt_pins.lower_strobe_read_n  = ~(s_dat & lo_ln);
      end
      nxt_dma.req   = ((nxt_state == ST_FETCH) | (nxt_state == ST_STORE)) & ~dma_ack_i;
      nxt_dma.we    = nxt_state == ST_STORE;
      nxt_dma.addr  = ad_ff;
      nxt_dma.wdata = wbuf_ff;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ebus_o <= '{addr_latch_n: 1'b1, byte_high_n: 1'b1, upper_strobe_write_n: 1'b1,
                     lower_strobe_read_n: 1'b1, read_write_n: 1'b1, ad_oe_n: 1'b1,
                     ad: 16'h0000};
         dma_o  <= '0;
      end else begin
         ebus_o <= nxt_pins;
         dma_o  <= nxt_dma;
      end
   end

   assign wb_ack_o = wb_ack_ff;
   assign wb_dat_o = wb_dat_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_addr_phase;
      (state_ff == ST_ADDR) [*2] ##1 (state_ff == ST_DATA);
   endsequence

   property p_ti_set;
      (state_ff == ST_DATA) && tmr_exp && !timer_enable_n_n |=> ti_ff;
   endproperty
   a_ti_set: assert property (p_ti_set) else $error("overflow flag missed");

   property p_lat_wait;
      latch && (state_ff == ST_DATA) && tmr_exp && (tmo != 4'h0) && !ack_s_ff
         |=> (state_ff == ST_DATA);
   endproperty
   a_lat_wait: assert property (p_lat_wait) else $error("strobe ended early");

   property p_ds_end;
      !latch && (state_ff == ST_DATA) && tmr_exp && !timer_enable_n_n |=> (state_ff == ST_GAP);
   endproperty
   a_ds_end: assert property (p_ds_end) else $error("cycle not ended");

   property p_fmt_err;
      fe_set |=> !start_ff ##1 fe_ff;
   endproperty
   a_fmt_err: assert property (p_fmt_err) else $error("format error missed");

   property p_halt_float;
      (state_ff == ST_HALT) && $past(state_ff == ST_HALT) |=> ebus_o.ad_oe_n;
   endproperty
   a_halt_float: assert property (p_halt_float) else $error("lines driven in halt");

   property p_halt_wait;
      (state_ff == ST_HALT) && halt_rq |=> (state_ff == ST_HALT);
   endproperty
   a_halt_wait: assert property (p_halt_wait) else $error("halt left early");

   property p_addr_len;
      $rose(state_ff == ST_ADDR) |-> s_addr_phase;
   endproperty
   a_addr_len: assert property (p_addr_len) else $error("address phase length");

   property p_no_stretch;
      (state_ff == ST_DATA) && (tmo == 4'h0) && $rose(state_ff == ST_DATA)
         |=> (state_ff != ST_DATA);
   endproperty
   a_no_stretch: assert property (p_no_stretch) else $error("stretch at zero");

   property p_gap_fast;
      $rose(state_ff == ST_GAP) && fast && !incr && !halt_rq && ack_s_ff
         && (cnt != 15'h0000) && !(block_ff && !write_ff && word_dn)
         && !(block_ff && write_ff && bptr_ff == 2'h0) && addr_sent_ff
         |=> (state_ff == ST_DATA);
   endproperty
   a_gap_fast: assert property (p_gap_fast) else $error("fast gap length");
endmodule

// ---- src/ebc_params.svh ----
// Offsets, field positions, reset values and cycle counts of the expansion bus controller
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH
`define EBC_OFF_CFG      32'h0000_007C
`define EBC_OFF_CMD      32'h0000_0080
`define EBC_OFF_AD       32'h0000_0088
`define EBC_OFF_STAT     32'h0000_008C
`define EBC_CFG_HALT_EN  31
`define EBC_CFG_RESUME   30
`define EBC_CFG_FAST     28
`define EBC_CFG_TMO_HI   25
`define EBC_CFG_TMO_LO   22
`define EBC_CFG_SLAVE16  19
`define EBC_CFG_INC      18
`define EBC_CFG_LATCH    17
`define EBC_CFG_TIMER_ENABLE_N_N   16
`define EBC_CFG_MASK     32'hD3FF_0000
`define EBC_CFG_RST      32'h0000_0000
`define EBC_CMD_RST      32'h0000_0000
`define EBC_AD_RST       32'h0000_0000
`define EBC_CMD_CNT_HI   31
`define EBC_CMD_CNT_LO   17
`define EBC_CMD_WRN      16
`define EBC_ST_ACTIVE    0
`define EBC_ST_TI        1
`define EBC_ST_FE        2
`define EBC_ADDR_CLKS    4'h2
`define EBC_GAP_FAST     4'h1
`define EBC_GAP_NORM     4'h2
`define EBC_GAP_INC_WR   4'h3
`define EBC_GAP_INC_RD   4'h4
`define EBC_IMM_MAX      15'h0004
`define EBC_WORD_STEP    32'h0000_0004
`endif

// ---- src/ebc_pkg.sv ----
// Types of the expansion bus controller
package ebc_pkg;
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_FETCH = 8'h02,
      ST_ADDR  = 8'h04,
      ST_DATA  = 8'h08,
      ST_GAP   = 8'h10,
      ST_STORE = 8'h20,
      ST_HALT  = 8'h40,
      ST_FIN   = 8'h80
   } ebc_state_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ebc_dma_t;

   typedef struct packed {
      logic        addr_latch_n;
      logic        byte_high_n;
      logic        upper_strobe_write_n;
      logic        lower_strobe_read_n;
      logic        read_write_n;
      logic        ad_oe_n;
      logic [15:0] ad;
   } ebc_pins_t;
endpackage

// ---- test/ebc_target_model.sv ----
// Target device model: latch/strobe peripheral with byte memory and ready stall
`timescale 1ns/1ps
module ebc_target_model
   import ebc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire ebc_pins_t  pins_i,
   input  wire logic [3:0] stall_i,
   output logic [15:0]     ad_o,
   output logic            rdy_o
);
   logic [7:0]  mem [0:255];
   logic [7:0]  a_ff     = 8'h00;
   logic        ale_ff   = 1'b1;
   logic [15:0] last_ff  = 16'h0000;
   logic [31:0] cnt_ff   = 32'h0;
   logic [31:0] width_ff = 32'h0;
   wire         rd_act   = !pins_i.lower_strobe_read_n;
   wire         wr_act   = !pins_i.upper_strobe_write_n;
   wire         act      = rd_act || wr_act;
   // ------------------------------
   // Ready and read data
   // ------------------------------
   // ready falls with strobe, released once the strobe has lasted stall_i clocks
   assign rdy_o = !(act && cnt_ff < 32'(stall_i));
   // Released bus shows the inverted last value, so stale data never matches
   assign ad_o = rd_act ? {mem[a_ff | 8'h01], mem[a_ff & 8'hFE]} : ~last_ff;
   // ------------------------------
   // Address, write capture, strobe width
   // ------------------------------
   always @(posedge clk_i) begin
      // Address taken only where the latch falls; ad carries data after that
      if (!pins_i.addr_latch_n && ale_ff) a_ff <= pins_i.ad[7:0];
      ale_ff <= pins_i.addr_latch_n;
      if (rd_act) last_ff <= ad_o;
      if (wr_act && !a_ff[0]) mem[a_ff] <= pins_i.ad[7:0];
      if (wr_act && !pins_i.byte_high_n) mem[a_ff | 8'h01] <= pins_i.ad[15:8];
      cnt_ff <= act ? cnt_ff + 32'h1 : 32'h0;
      if (!act && cnt_ff != 32'h0) width_ff <= cnt_ff;
   end
endmodule

// ---- test/expansion_bus_transfer_control_bench.sv ----
// Self-checking bench of the expansion bus transfer controller
`timescale 1ns/1ps
`include "ebc_params.svh"
module expansion_bus_transfer_control_bench
   import ebc_pkg::*;
;
   typedef struct {logic [31:0] exp; logic [31:0] msk; string nm;} ebc_note_t;
   logic        clk_i     = 1'b0;
   logic        rst_i     = 1'b1;
   logic        req_ff    = 1'b0;
   logic        we_ff     = 1'b0;
   logic        chk_ff    = 1'b0;
   logic [31:0] adr_ff    = 32'h0;
   logic [31:0] dat_ff    = 32'h0;
   logic [31:0] rd_ff;
   logic [3:0]  sel_ff    = 4'hF;
   logic        dack_ff   = 1'b0;
   logic [31:0] drd_ff    = 32'h0;
   logic [31:0] dw_ff     = 32'h0;
   logic        halt_n_ff = 1'b1;
   logic        inc_on    = 1'b1;
   logic [3:0]  stall_ff  = 4'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   ebc_dma_t    dma_o;
   ebc_pins_t   ebus_o;
   logic [15:0] ad;
   logic        rdy;
   int          mismatches = 0;
   int          checked    = 0;
   int          cycles     = 0;
   ebc_note_t   notes [$];
   ebc_note_t   cur;

   ebc_top dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req_ff), .wb_stb_i(req_ff),
      .wb_we_i(we_ff), .wb_adr_i(adr_ff), .wb_sel_i(sel_ff), .wb_dat_i(dat_ff),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_o(dma_o), .dma_ack_i(dack_ff),
      .dma_rdata_i(drd_ff), .ebus_o(ebus_o), .ad_i(ad), .target_ack_ready_i(rdy),
      .ext_halt_i(halt_n_ff)
   );
   ebc_target_model tgt_u (
      .clk_i(clk_i), .pins_i(ebus_o), .stall_i(stall_ff), .ad_o(ad), .rdy_o(rdy)
   );

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   // PCI side answers each fetch with a counting word, one-cycle ack
   always @(posedge clk_i) begin
      dack_ff <= dma_o.req && !dack_ff;
      drd_ff  <= 32'hA0B0_C0D0 + dw_ff;
      if (dma_o.req && !dack_ff) dw_ff <= dw_ff + 32'h1;
   end
   // Oldest note is compared against each checked read
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && chk_ff && notes.size() > 0) begin
         cur = notes.pop_front();
         check(cur.nm, cur.exp, wb_dat_o & cur.msk);
      end
   end

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] v, input logic c);
      @(posedge clk_i);
      req_ff <= 1'b1;
      we_ff  <= w;
      adr_ff <= a;
      dat_ff <= v;
      chk_ff <= c;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd_ff = wb_dat_o;
      req_ff <= 1'b0;
      chk_ff <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m,
                     input string nm);
      notes.push_back(ebc_note_t'{e & m, m, nm});
      wb(1'b0, a, 32'h0, 1'b1);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 300; i++) begin
         wb(1'b0, `EBC_OFF_STAT, 32'h0, 1'b0);
         if (rd_ff[`EBC_ST_ACTIVE] === 1'b0) break;
      end
   endtask
   function automatic logic [31:0] cfg(input logic [3:0] t, input logic h, input logic r);
      cfg = 32'h0;
      cfg[`EBC_CFG_TMO_HI:`EBC_CFG_TMO_LO] = t;
      cfg[`EBC_CFG_HALT_EN] = h;
      cfg[`EBC_CFG_RESUME] = r;
      // Fast bit is random: it must not matter in increment mode
      cfg[`EBC_CFG_FAST] = inc_on ? 1'($urandom_range(1, 0)) : 1'b1;
      cfg[`EBC_CFG_SLAVE16] = 1'b1;
      cfg[`EBC_CFG_INC] = inc_on;
      cfg[`EBC_CFG_LATCH] = 1'b1;
      cfg[`EBC_CFG_TIMER_ENABLE_N_N] = 1'b0;
   endfunction
   task automatic start(input logic [3:0] t, input logic h, input logic r,
                        input logic [14:0] n, input logic wn, input logic [15:0] a,
                        input logic [31:0] v);
      wb(1'b1, `EBC_OFF_CFG, cfg(t, h, r), 1'b0);
      wb(1'b1, `EBC_OFF_AD, v, 1'b0);
      wb(1'b1, `EBC_OFF_CMD, {n, wn, a}, 1'b0);
   endtask

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      logic [31:0] d;
      logic [31:0] w;
      logic [31:0] e;
      logic [3:0]  t;
      void'($urandom(32'h46D9));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`EBC_OFF_CFG, `EBC_CFG_RST, 32'hFFFF_FFFF, "config");
      rd(`EBC_OFF_CMD, `EBC_CMD_RST, 32'hFFFF_FFFF, "command");
      rd(`EBC_OFF_AD, `EBC_AD_RST, 32'hFFFF_FFFF, "addr data");
      rd(`EBC_OFF_STAT, 32'h0, 32'hFFFF_FFFF, "status");
      rd(32'h0000_0040, 32'h0, 32'hFFFF_FFFF, "unmapped");
      wb(1'b1, `EBC_OFF_CFG, 32'hFFFF_FFFF, 1'b0);
      rd(`EBC_OFF_CFG, `EBC_CFG_MASK, 32'hFFFF_FFFF, "config bits");
      $display("test registers done");
      d = $urandom();
      t = 4'($urandom_range(3, 0));
      start(t, 1'b0, 1'b0, 15'h0004, 1'b0, 16'h0010, d);
      wait_idle();
      for (int i = 0; i < 4; i++) begin
         check("byte out", 32'(d[8*i +: 8]), 32'(tgt_u.mem[16 + i]));
      end
      check("strobe width", 32'(t) + 32'h1, tgt_u.width_ff);
      rd(`EBC_OFF_STAT, 32'h2, 32'h2, "timer flag");
      wb(1'b1, `EBC_OFF_STAT, 32'h2, 1'b0);
      rd(`EBC_OFF_STAT, 32'h0, 32'h2, "timer clear");
      start(4'h3, 1'b0, 1'b0, 15'h0004, 1'b1, 16'h0010, 32'h0);
      wait_idle();
      rd(`EBC_OFF_AD, d, 32'hFFFF_FFFF, "read data");
      $display("test immediate done");
      start(4'h0, 1'b0, 1'b0, 15'h0002, 1'b0, 16'h0013, 32'h0);
      wait_idle();
      rd(`EBC_OFF_STAT, 32'h4, 32'h5, "format error");
      check("no transfer", 32'(d[31:24]), 32'(tgt_u.mem[19]));
      wb(1'b1, `EBC_OFF_STAT, 32'h4, 1'b0);
      rd(`EBC_OFF_STAT, 32'h0, 32'h4, "format clear");
      $display("test format done");
      stall_ff <= 4'h3;
      start(4'h0, 1'b0, 1'b0, 15'h0001, 1'b0, 16'h0030, d);
      wait_idle();
      check("unstretched", 32'h1, tgt_u.width_ff);
      stall_ff <= 4'h6;
      // Two sync flops add two clocks to the one-clock pin delay of ready: three is the least timeout
      start(4'h3, 1'b0, 1'b0, 15'h0001, 1'b0, 16'h0030, d);
      wait_idle();
      w = tgt_u.width_ff;
      check("stretched", 32'h1, 32'(w > 32'h6));
      start(4'h4, 1'b0, 1'b0, 15'h0001, 1'b0, 16'h0030, d);
      wait_idle();
      check("wider timeout", w, tgt_u.width_ff);
      stall_ff <= 4'h0;
      $display("test stretch done");
      e = dw_ff;
      start(4'h0, 1'b1, 1'b1, 15'h0010, 1'b0, 16'h0020, 32'h0000_1000);
      repeat ($urandom_range(30, 20)) @(posedge clk_i);
      halt_n_ff <= 1'b0;
      repeat (40) @(posedge clk_i);
      check("bus floated", 32'h1, 32'(ebus_o.ad_oe_n));
      rd(`EBC_OFF_STAT, 32'h1, 32'h1, "active in halt");
      halt_n_ff <= 1'b1;
      wait_idle();
      for (int i = 0; i < 16; i++) begin
         w = 32'hA0B0_C0D0 + e + 32'(i / 4);
         check("block byte", 32'(w[8*(i%4) +: 8]), 32'(tgt_u.mem[32 + i]));
      end
      rd(`EBC_OFF_AD, 32'h0000_1010, 32'hFFFF_FFFF, "dma address");
      rd(`EBC_OFF_CMD, 32'h0, 32'hFFFE_0000, "count left");
      start(4'h0, 1'b1, 1'b0, 15'h0020, 1'b0, 16'h0040, 32'h0000_2000);
      repeat (4) @(posedge clk_i);
      halt_n_ff <= 1'b0;
      wait_idle();
      halt_n_ff <= 1'b1;
      wb(1'b0, `EBC_OFF_CMD, 32'h0, 1'b0);
      check("halt stop", 32'h1, 32'(rd_ff[31:17] >= 15'h0018));
      $display("test halt done");
      // Non-increment burst: all halves land on the one latched address
      e = dw_ff;
      inc_on = 1'b0;
      start(4'h0, 1'b0, 1'b0, 15'h0008, 1'b0, 16'h0050, 32'h0000_4000);
      wait_idle();
      w = 32'hA0B0_C0D1 + e;
      check("burst half", {16'h0, w[31:16]}, {16'h0, tgt_u.mem[81], tgt_u.mem[80]});
      inc_on = 1'b1;
      $display("test burst done");
      for (int k = 0; k < 2; k++) begin
         start(4'h0, 1'b0, 1'b0, k ? 15'h0008 : 15'h0006, 1'b1, k ? 16'h0020 : 16'h0011,
               32'h0000_3000);
         wait_idle();
         e = k ? 32'h0000_3008 : 32'h0000_300C;
         rd(`EBC_OFF_AD, e, 32'hFFFF_FFFF, "read block end");
      end
      $display("test read block done");
      final_report();
   end
endmodule
